// >>> include/wdt_pkg.sv
package wdt_pkg;
	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
	localparam logic [7:0] ADDR_WATCHDOG_COUNT = 8'hFF;
	localparam logic [7:0] ADDR_WATCHDOG_CTRL = 8'h80;
	// ****************************************
	// fields and reset values
	// ****************************************
	localparam int POWER_DOWN_BIT = 1;
	localparam int UNLOCK_BIT = 4;
	localparam int IDLE_BIT = 0;
	localparam logic [7:0] POWER_CONTROL_RST = 8'h00;
	localparam logic [7:0] WATCHDOG_COUNT_RST = 8'h00;
	localparam logic [7:0] POWER_CONTROL_RW_MASK = 8'hEF;
	// ****************************************
	// timing
	// ****************************************
	localparam int OSC_DIV = 6;
	localparam int PRESCALE_BITS = 11;
	localparam int PULSE_MACHINE_CYCLES = 3;
	localparam int PULSE_CYCLES = OSC_DIV * PULSE_MACHINE_CYCLES;
	localparam logic [2:0] MC_LAST = 3'(OSC_DIV - 1);
	localparam logic [4:0] PULSE_LAST = 5'(PULSE_CYCLES - 1);
	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {
		WDT_RUN = 2'b00,
		WDT_PULSE = 2'b01
	} wdt_state_t;
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [7:0] adr;
		logic [31:0] dat;
	} wdt_wb_req_t;
	typedef struct packed {
		wdt_state_t st;
		logic [2:0] mc_cnt;
		logic [PRESCALE_BITS-1:0] pre;
		logic [7:0] count;
		logic [7:0] power_control;
		logic [4:0] pulse_cnt;
		logic ack;
		logic [31:0] rdat;
		logic [7:0] ovf_cnt;
	} wdt_regs_t;
endpackage

// >>> src/wdt_top.sv
`timescale 1ns/1ps
// What this block does
// - eight-bit up timer advanced by carry of an eleven-bit prescaler
// - prescaler ticks once per six oscillator clocks, the machine cycle
// - timer steps once every 2048 prescaler ticks
// - timer rollover from maximum issues a brief internal reset
// - overflow also drives a reset pin pulse three machine cycles long
// - enable pin low keeps watchdog active, software cannot disable it
// - enable pin high disables watchdog, no resets generated
// - accepted timer write clears unlock flag automatically
// - timer write with unlock flag clear is ignored
// - zero load gives longest interval, all ones the shortest
// - prescaler and timer keep counting in idle mode
// - with watchdog enabled, power-down bit cannot be set, reads zero
// - timer at address FF, power control at 87
module wdt_top
	import wdt_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// watchdog pins
	input wire logic watchdog_enable_pin_n,
	input wire logic ext_reset_in,
	output logic rst_pin_o,
	output logic rst_pin_oe_n,
	output logic sys_reset_o,
	output logic power_down_o,
	output logic idle_o
);
	// ****************************************
	// elaboration checks
	// ****************************************
	if (PRESCALE_BITS != 11 || OSC_DIV < 2 || OSC_DIV > 8) begin : g_chk
		$error("wdt_top: unsupported prescaler setup");
	end

	wdt_wb_req_t req;
	wdt_regs_t cur_ff;
	wdt_regs_t nxt_ff;
	logic wd_on;
	logic mc_tick;
	logic pre_carry;
	logic bus_go;
	logic wr_byte;
	logic wr_count;
	logic wr_power_control;
	logic ovf;

	function automatic logic [31:0] rd_mux(input logic [7:0] a, input wdt_regs_t s,
		input logic on);
		logic [31:0] r;
		r = 32'h0000_0000;
		case (a)
			ADDR_POWER_CONTROL: r = {24'h00_0000, s.power_control};
			ADDR_WATCHDOG_COUNT: r = {24'h00_0000, s.count};
			ADDR_WATCHDOG_CTRL: r = {24'h00_0000, s.ovf_cnt[6:0], on};
			default: r = 32'h0000_0000;
		endcase
		return r;
	endfunction

	assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
		adr: wb_adr_i, dat: wb_dat_i};

	// ****************************************
	// combinational next state
	// ****************************************
	always_comb begin
		nxt_ff = cur_ff;
		wd_on = ~watchdog_enable_pin_n;
		bus_go = req.cyc && req.stb && !cur_ff.ack;
		wr_byte = bus_go && req.we && req.sel[0];
		wr_count = wr_byte && (req.adr == ADDR_WATCHDOG_COUNT);
		wr_power_control = wr_byte && (req.adr == ADDR_POWER_CONTROL);
		// machine cycle = six clocks; idle does not gate it
		mc_tick = (cur_ff.mc_cnt == MC_LAST);
		pre_carry = mc_tick && (&cur_ff.pre);
		ovf = wd_on && pre_carry && (&cur_ff.count) && cur_ff.st == WDT_RUN;
		nxt_ff.ack = bus_go;
		nxt_ff.rdat = bus_go ? rd_mux(req.adr, cur_ff, wd_on) : 32'h0000_0000;
		nxt_ff.mc_cnt = mc_tick ? 3'h0 : cur_ff.mc_cnt + 3'h1;
		if (mc_tick) begin
			nxt_ff.pre = cur_ff.pre + 11'h001;
		end
		if (pre_carry) begin
			// overflow wraps to zero, the longest interval after a reset
			nxt_ff.count = cur_ff.count + 8'h01;
		end
		if (wr_power_control) begin
			nxt_ff.power_control = (req.dat[7:0] & POWER_CONTROL_RW_MASK) | (cur_ff.power_control & ~POWER_CONTROL_RW_MASK);
			if (req.dat[UNLOCK_BIT]) begin
				nxt_ff.power_control[UNLOCK_BIT] = 1'b1;
			end
		end
		if (wd_on) begin
			nxt_ff.power_control[POWER_DOWN_BIT] = 1'b0;
		end
		if (wr_count && cur_ff.power_control[UNLOCK_BIT]) begin
			// a reload also restarts the prescaler for a clean interval
			nxt_ff.count = req.dat[7:0];
			nxt_ff.pre = '0;
			nxt_ff.power_control[UNLOCK_BIT] = 1'b0;
		end
		case (cur_ff.st)
			WDT_RUN: begin
				if (ovf) begin
					nxt_ff.st = WDT_PULSE;
					nxt_ff.pulse_cnt = 5'h00;
					nxt_ff.ovf_cnt = cur_ff.ovf_cnt + 8'h01;
				end
			end
			WDT_PULSE: begin
				// whole-chip reset: unlock flag and prescaler start clean
				nxt_ff.pre = '0;
				nxt_ff.mc_cnt = 3'h0;
				nxt_ff.count = WATCHDOG_COUNT_RST;
				nxt_ff.power_control = POWER_CONTROL_RST;
				if (cur_ff.pulse_cnt == PULSE_LAST) begin
					nxt_ff.st = WDT_RUN;
				end else begin
					nxt_ff.pulse_cnt = cur_ff.pulse_cnt + 5'h01;
				end
			end
			default: nxt_ff.st = WDT_RUN;
		endcase
		if (ext_reset_in) begin
			nxt_ff.pre = '0;
			nxt_ff.power_control = POWER_CONTROL_RST;
			nxt_ff.count = WATCHDOG_COUNT_RST;
		end
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cur_ff <= '{st: WDT_RUN, mc_cnt: 3'h0, pre: '0, count: WATCHDOG_COUNT_RST,
				power_control: POWER_CONTROL_RST, pulse_cnt: 5'h00, ack: 1'b0,
				rdat: 32'h0000_0000, ovf_cnt: 8'h00};
		end else begin
			cur_ff <= nxt_ff;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign wb_ack_o = cur_ff.ack;
	assign wb_dat_o = cur_ff.rdat;
	assign sys_reset_o = (cur_ff.st == WDT_PULSE);
	// pin is driven high during the pulse; a capacitor may swallow it, the internal reset stays
	assign rst_pin_o = 1'b1;
	assign rst_pin_oe_n = ~(cur_ff.st == WDT_PULSE);
	assign power_down_o = cur_ff.power_control[POWER_DOWN_BIT];
	assign idle_o = cur_ff.power_control[IDLE_BIT];

	// ****************************************
	// checks
	// ****************************************
	AST_PULSE_LEN: assert property (@(posedge clk) disable iff (rst)
		$rose(sys_reset_o) |-> sys_reset_o [*8] ##0 1)
		else $error("reset pulse shorter than expected");
	AST_PULSE_END: assert property (@(posedge clk) disable iff (rst)
		$rose(sys_reset_o) |-> ##18 !sys_reset_o)
		else $error("reset pulse not eighteen clocks");
	AST_OVF_PULSE: assert property (@(posedge clk) disable iff (rst)
		ovf |=> sys_reset_o)
		else $error("overflow gave no reset");
	AST_DISABLED: assert property (@(posedge clk) disable iff (rst)
		watchdog_enable_pin_n |-> !ovf)
		else $error("overflow while disabled");
	AST_PD_BLOCK: assert property (@(posedge clk) disable iff (rst)
		!watchdog_enable_pin_n && $past(!watchdog_enable_pin_n) |-> !power_down_o)
		else $error("power-down set while watchdog on");
	AST_LOCKED_WR: assert property (@(posedge clk) disable iff (rst)
		wr_count && !cur_ff.power_control[UNLOCK_BIT] && !pre_carry && !ext_reset_in
		&& cur_ff.st == WDT_RUN |=> $stable(cur_ff.count))
		else $error("locked write changed timer");
	AST_UNLOCK_CLR: assert property (@(posedge clk) disable iff (rst)
		wr_count && cur_ff.power_control[UNLOCK_BIT] && !ext_reset_in && cur_ff.st == WDT_RUN
		|=> !cur_ff.power_control[UNLOCK_BIT] && cur_ff.count == $past(req.dat[7:0]))
		else $error("reload did not load or relock");
	AST_STEP: assert property (@(posedge clk) disable iff (rst)
		pre_carry && !wr_count && !ext_reset_in && cur_ff.st == WDT_RUN
		|=> cur_ff.count == 8'($past(cur_ff.count) + 8'h01))
		else $error("timer did not step on carry");
	// the pulse holds the divider at zero, so an overflow tick starts no normal cycle
	AST_MC: assert property (@(posedge clk) disable iff (rst)
		mc_tick && !ovf && !ext_reset_in |=> !mc_tick [*5] ##1 mc_tick)
		else $error("machine cycle not six clocks");
	// ****************************************
	// bus checks
	// ****************************************
	AST_ACK_ONE: assert property (@(posedge clk) disable iff (rst)
		wb_ack_o
		|=> !wb_ack_o)
		else $error("ack stood longer than one cycle");
	AST_ACK_ANS: assert property (@(posedge clk) disable iff (rst)
		wb_cyc_i && wb_stb_i && !wb_ack_o
		|=> wb_ack_o)
		else $error("request not answered next cycle");
	AST_RD_COUNT: assert property (@(posedge clk) disable iff (rst)
		bus_go && !req.we && req.adr == ADDR_WATCHDOG_COUNT
		|=> wb_dat_o == {24'h00_0000, $past(cur_ff.count)})
		else $error("timer read returned wrong value");
	AST_RD_ZERO: assert property (@(posedge clk) disable iff (rst)
		!wb_ack_o
		|-> wb_dat_o == 32'h0000_0000)
		else $error("read data not zero outside ack");
	AST_RD_PD: assert property (@(posedge clk) disable iff (rst)
		bus_go && !req.we && req.adr == ADDR_POWER_CONTROL && !watchdog_enable_pin_n
		&& $past(!watchdog_enable_pin_n) |=> !wb_dat_o[POWER_DOWN_BIT])
		else $error("power-down bit read one while watchdog on");
	// ****************************************
	// timer and reset checks
	// ****************************************
	AST_PIN_OE: assert property (@(posedge clk) disable iff (rst)
		1'b1
		|-> rst_pin_oe_n == !sys_reset_o)
		else $error("pin drive and internal reset disagree");
	AST_PRE_STEP: assert property (@(posedge clk) disable iff (rst)
		mc_tick && !wr_count && cur_ff.st == WDT_RUN && !ext_reset_in
		|=> cur_ff.pre == 11'($past(cur_ff.pre) + 11'h001))
		else $error("prescaler did not step on machine cycle");
	AST_PRE_HOLD: assert property (@(posedge clk) disable iff (rst)
		!mc_tick && !wr_count && cur_ff.st == WDT_RUN && !ext_reset_in
		|=> $stable(cur_ff.pre))
		else $error("prescaler moved between machine cycles");
	AST_UNLOCK_HOLD: assert property (@(posedge clk) disable iff (rst)
		cur_ff.power_control[UNLOCK_BIT] && !wr_count && cur_ff.st == WDT_RUN && !ext_reset_in
		|=> cur_ff.power_control[UNLOCK_BIT])
		else $error("unlock flag lost without a reload");
	AST_EXT_CLR: assert property (@(posedge clk) disable iff (rst)
		ext_reset_in
		|=> cur_ff.pre == '0 && !cur_ff.power_control[UNLOCK_BIT])
		else $error("system reset left prescaler or unlock flag");
	AST_PULSE_CLR: assert property (@(posedge clk) disable iff (rst)
		sys_reset_o
		|=> !cur_ff.power_control[UNLOCK_BIT] && cur_ff.pre == '0)
		else $error("watchdog reset left prescaler or unlock flag");
	AST_ENABLED_OVF: assert property (@(posedge clk) disable iff (rst)
		!watchdog_enable_pin_n && pre_carry && cur_ff.count == 8'hFF && !sys_reset_o
		|=> sys_reset_o)
		else $error("enabled watchdog missed an overflow");
endmodule

// >>> testbench/test_wdt_top.sv
`timescale 1ns/1ps
module test_wdt_top
	import wdt_pkg::*;
;
	// ****************************************
	// signals
	// ****************************************
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [3:0] wb_sel_i = 4'h0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o, rst_pin_o, rst_pin_oe_n, sys_reset_o, power_down_o, idle_o;
	logic watchdog_enable_pin_n = 1'b0;
	logic ext_reset_in = 1'b0;
	logic [7:0] q;
	int n_fail = 0;
	int cmp_count = 0;
	int cyc_n = 0;
	int k;
	always #5 clk = ~clk;
	wdt_top dut_u (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_sel_i, .wb_adr_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .watchdog_enable_pin_n, .ext_reset_in,
		.rst_pin_o, .rst_pin_oe_n, .sys_reset_o, .power_down_o, .idle_o);
	// ****************************************
	// tasks
	// ****************************************
	task print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// bus cycle waits for ack under a bound, never a fixed latency
	task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int t;
		t = 0;
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_sel_i <= 4'hF;
		wb_adr_i <= a;
		wb_dat_i <= {24'h0, d};
		do begin
			@(posedge clk);
			t++;
		end while (wb_ack_o !== 1'b1 && t < 20);
		q = wb_dat_o[7:0];
		cmp_count++;
		if (t >= 20 || (!w && wb_dat_o[31:8] !== 24'h00_0000)) begin
			n_fail++;
			$display("mismatch at %0t: no ack or upper read bits set", $time);
		end
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	// ****************************************
	// hang guard
	// ****************************************
	always @(posedge clk) begin
		cyc_n++;
		if (cyc_n > 40000) begin
			n_fail++;
			print_verdict();
		end
	end
	// ****************************************
	// tests
	// ****************************************
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		wb(1'b0, ADDR_POWER_CONTROL, 8'h00);
		chk(q, POWER_CONTROL_RST);
		wb(1'b0, ADDR_WATCHDOG_COUNT, 8'h00);
		chk(q, WATCHDOG_COUNT_RST);
		wb(1'b1, ADDR_WATCHDOG_COUNT, 8'h5A);
		wb(1'b0, ADDR_WATCHDOG_COUNT, 8'h00);
		chk(q, 8'h00);
		wb(1'b1, ADDR_POWER_CONTROL, 8'h13);
		wb(1'b0, ADDR_POWER_CONTROL, 8'h00);
		chk(q, 8'h11);
		chk({7'h0, idle_o}, 8'h01);
		wb(1'b1, ADDR_WATCHDOG_COUNT, 8'hFF);
		wb(1'b0, ADDR_WATCHDOG_COUNT, 8'h00);
		chk(q, 8'hFF);
		wb(1'b0, ADDR_POWER_CONTROL, 8'h00);
		chk(q, 8'h01);
		wb(1'b0, 8'h10, 8'h00);
		chk(q, 8'h00);
		$display("test registers done");
		// idle stays set while waiting: the timer must still run out
		k = 0;
		while (sys_reset_o !== 1'b1 && k < 13000) begin
			@(posedge clk);
			k++;
		end
		chk(8'(k > 12200 && k < 12300), 8'h01);
		k = 0;
		while (sys_reset_o === 1'b1 && rst_pin_oe_n === 1'b0 && k < 40) begin
			@(posedge clk);
			k++;
		end
		chk(8'(k), 8'(PULSE_CYCLES));
		wb(1'b0, ADDR_POWER_CONTROL, 8'h00);
		chk(q, 8'h00);
		wb(1'b0, ADDR_WATCHDOG_CTRL, 8'h00);
		chk(q, 8'h03);
		chk({7'h0, rst_pin_o}, 8'h01);
		$display("test overflow done");
		wb(1'b1, ADDR_POWER_CONTROL, 8'h10);
		@(posedge clk);
		ext_reset_in <= 1'b1;
		@(posedge clk);
		ext_reset_in <= 1'b0;
		wb(1'b0, ADDR_POWER_CONTROL, 8'h00);
		chk(q, 8'h00);
		$display("test system reset done");
		watchdog_enable_pin_n <= 1'b1;
		wb(1'b1, ADDR_POWER_CONTROL, 8'h12);
		wb(1'b1, ADDR_WATCHDOG_COUNT, 8'hFF);
		wb(1'b0, ADDR_POWER_CONTROL, 8'h00);
		chk(q, 8'h02);
		chk({7'h0, power_down_o}, 8'h01);
		k = 0;
		repeat (13000) begin
			@(posedge clk);
			if (sys_reset_o !== 1'b0 || rst_pin_oe_n !== 1'b1)
				k++;
		end
		chk(8'(k), 8'h00);
		$display("test disabled done");
		print_verdict();
	end
endmodule
